/* File: logic/cmeu_device.sv */
`timescale 1ns/100ps
`default_nettype none
module cmeu_device #(
  parameter int CODE_DEPTH = 1024,          // Code memory bytes
  parameter int DATA_DEPTH = 64,            // Data memory bytes
  parameter logic [7:0] NV_RESET = cmeu_pkg::INIT_PROT_RESET
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic prog_mode_i,             // Programming mode active
  input wire logic [9:0] code_rd_addr_i,    // Core fetch address
  output logic [7:0] code_rd_data_o,        // Core fetch data
  output logic [7:0] protect_shadow_o,      // Volatile protect copy
  output logic [7:0] protect_stored_o,      // Non-volatile protect copy
  output logic erase_even_done_o,           // Even pages erased
  output logic erase_odd_done_o,            // Odd pages erased
  cmeu_link_if.dev link
);
  // ****************************************
  // State and storage
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SHIFT = 3'h1,
    ST_LAUNCH = 3'h2,
    ST_EXEC = 3'h3,
    ST_ERASE = 3'h4
  } cmeu_dev_state_type;
  cmeu_dev_state_type state;
  logic [7:0] code_mem [CODE_DEPTH];        // Code memory array
  logic [7:0] data_mem [DATA_DEPTH];        // Data memory, never erased
  logic lk_s1, lk_s2, lk_d;                 // Link clock synchroniser
  logic ld_s1, ld_s2;                       // Strobe synchroniser
  logic si_s1, si_s2;                       // Data synchroniser
  logic rise;                               // Link clock rising edge
  logic [31:0] cmd;                         // Command shift register
  logic [31:0] rsp_sh;                      // Response shift register
  logic rsp_reject;                         // Last command refused
  logic [7:0] rsp_data;                     // Last read data
  logic edge_cnt;                           // Launch pulse counter
  logic [9:0] erase_addr;                   // Erase walk pointer
  logic erase_odd;                          // Walk targets odd pages
  logic [9:0] addr;                         // Command address field
  logic [7:0] wdata;                        // Command data field
  logic is_erase;                           // Valid erase command
  logic protected_now;                      // Shadow says locked
  logic accept;                             // Ordinary access allowed
  logic erase_last;                         // Final walk step
  assign addr = cmd[cmeu_pkg::CMD_ADDR_HI:cmeu_pkg::CMD_ADDR_LO];
  assign wdata = cmd[cmeu_pkg::CMD_DATA_HI:0];
  assign rise = lk_s2 & ~lk_d;
  // Erase needs write format, bit 22, code target and a page selector
  assign is_erase = cmd[cmeu_pkg::CMD_WRITE_POS]
    & cmd[cmeu_pkg::CMD_ERASE_POS] & cmd[cmeu_pkg::CMD_CODE_POS]
    & ((addr == cmeu_pkg::ADDR_EVEN) | (addr == cmeu_pkg::ADDR_ODD));
  // Checks read the shadow, never the stored copy
  assign protected_now = protect_shadow_o[cmeu_pkg::WRITE_PROTECT_POS]
    | protect_shadow_o[cmeu_pkg::READ_PROTECT_POS];
  // Erase bits never reach an ordinary access
  assign accept = ~protected_now & ~cmd[cmeu_pkg::CMD_ERASE_POS];
  assign erase_last = (erase_addr == 10'(CODE_DEPTH - 1));
  // ****************************************
  // Input synchronisers
  // ****************************************
  // Two flops on every link pin before any logic looks at it
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      {lk_s1, lk_s2, lk_d} <= 3'h0;
      {ld_s1, ld_s2, si_s1, si_s2} <= 4'h0;
    end
    else
    begin
      lk_s1 <= link.link_clk;
      lk_s2 <= lk_s1;
      lk_d <= lk_s2;
      ld_s1 <= link.load;
      ld_s2 <= ld_s1;
      si_s1 <= link.shift_in;
      si_s2 <= si_s1;
    end
  end

  // ****************************************
  // Link state machine
  // ****************************************
  // Link is ignored outside programming mode
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_IDLE;
      cmd <= 32'h0;
      rsp_sh <= 32'h0;
      link.shift_out <= 1'b1;
      edge_cnt <= 1'b0;
      erase_addr <= 10'h0;
      erase_odd <= 1'b0;
    end
    else if (!prog_mode_i)
    begin
      state <= ST_IDLE;
      link.shift_out <= 1'b1;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          // Strobe high: present first response bit
          if (ld_s2)
          begin
            rsp_sh <= {rsp_reject, 23'h0, rsp_data};
            link.shift_out <= rsp_reject;
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (rise)
          begin
            cmd <= {cmd[30:0], si_s2};
            rsp_sh <= {rsp_sh[30:0], 1'b0};
            link.shift_out <= rsp_sh[30];
          end
          else if (!ld_s2)
          begin
            edge_cnt <= 1'b0;
            state <= ST_LAUNCH;
          end
        end
        ST_LAUNCH:
        begin
          // Strobe back high aborts the launch
          if (ld_s2)
            state <= ST_IDLE;
          else if (rise && !edge_cnt)
          begin
            link.shift_out <= 1'b0;
            edge_cnt <= 1'b1;
          end
          else if (rise)
            state <= ST_EXEC;
        end
        ST_EXEC:
        begin
          // Erase proceeds even with protection set
          if (is_erase)
          begin
            erase_addr <= 10'h0;
            erase_odd <= (addr == cmeu_pkg::ADDR_ODD);
            state <= ST_ERASE;
          end
          else
          begin
            link.shift_out <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_ERASE:
        begin
          // One byte per cycle across the whole array
          erase_addr <= erase_addr + 10'h1;
          if (erase_last)
          begin
            link.shift_out <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
  // ****************************************
  // Response capture
  // ****************************************
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      rsp_reject <= 1'b0;
      rsp_data <= 8'h0;
    end
    else if (prog_mode_i && state == ST_EXEC)
    begin
      rsp_reject <= ~is_erase & ~accept;
      if (!accept || cmd[cmeu_pkg::CMD_WRITE_POS])
        rsp_data <= 8'h0;
      else if (cmd[cmeu_pkg::CMD_INIT_POS])
        rsp_data <= protect_shadow_o;
      else if (cmd[cmeu_pkg::CMD_CODE_POS])
        rsp_data <= code_mem[addr];
      else
        rsp_data <= data_mem[addr[5:0]];
    end
  end
  // ****************************************
  // Code memory
  // ****************************************
  // Erase fills only pages of the chosen parity with the data byte
  always_ff @(posedge core_clk_i)
  begin
    if (state == ST_ERASE && erase_addr[cmeu_pkg::PAGE_SEL_POS] == erase_odd)
      code_mem[erase_addr] <= wdata;
    else if (state == ST_EXEC && accept && cmd[cmeu_pkg::CMD_WRITE_POS]
      && cmd[cmeu_pkg::CMD_CODE_POS] && !cmd[cmeu_pkg::CMD_INIT_POS])
      code_mem[addr] <= wdata;
  end
  // Core fetch port for normal running
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      code_rd_data_o <= 8'h0;
    else
      code_rd_data_o <= code_mem[code_rd_addr_i];
  end

  // ****************************************
  // Data memory
  // ****************************************
  // Erase walk never writes here
  always_ff @(posedge core_clk_i)
  begin
    if (state == ST_EXEC && accept && cmd[cmeu_pkg::CMD_WRITE_POS]
      && !cmd[cmeu_pkg::CMD_CODE_POS] && !cmd[cmeu_pkg::CMD_INIT_POS])
      data_mem[addr[5:0]] <= wdata;
  end
  // ****************************************
  // Erase completion flags
  // ****************************************
  // Flags live only for one programming session
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || !prog_mode_i)
    begin
      erase_even_done_o <= 1'b0;
      erase_odd_done_o <= 1'b0;
    end
    else if (state == ST_ERASE && erase_last)
    begin
      if (erase_odd)
        erase_odd_done_o <= 1'b1;
      else
        erase_even_done_o <= 1'b1;
    end
  end

  // ****************************************
  // Protection register, stored and shadow
  // ****************************************
  // Shadow reloads from the stored copy between sessions
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      protect_stored_o <= NV_RESET;
      protect_shadow_o <= NV_RESET;
    end
    else if (!prog_mode_i)
      protect_shadow_o <= protect_stored_o;
    else if (erase_even_done_o && erase_odd_done_o && |protect_shadow_o)
      // Clear holds shadow at zero this session; later stored writes still land
      protect_shadow_o <= 8'h0;
    else if (state == ST_EXEC && accept && cmd[cmeu_pkg::CMD_WRITE_POS]
      && cmd[cmeu_pkg::CMD_INIT_POS] && addr == cmeu_pkg::INIT_PROT_OFFSET)
    begin
      protect_stored_o <= wdata;
      protect_shadow_o <= wdata;
    end
  end
endmodule : cmeu_device
`default_nettype wire

/* File: logic/cmeu_pkg.sv */
package cmeu_pkg;
  // ****************************************
  // Command word layout
  // ****************************************
  localparam int CMD_W = 32;                // Command and response width
  localparam int CMD_WRITE_POS = 31;        // 1 write, 0 read
  localparam int CMD_INIT_POS = 30;         // Init register target
  localparam int CMD_CODE_POS = 28;         // Code memory target
  localparam int CMD_ERASE_POS = 22;        // Erase mode selector
  localparam int CMD_ADDR_HI = 17;          // Address field top
  localparam int CMD_ADDR_LO = 8;           // Address field bottom
  localparam int CMD_DATA_HI = 7;           // Data field top
  localparam logic [9:0] ADDR_EVEN = 10'h000; // Even page erase address
  localparam logic [9:0] ADDR_ODD = 10'h010;  // Odd page erase address
  localparam logic [9:0] INIT_PROT_OFFSET = 10'h0bb; // Protect register
  localparam int PAGE_SEL_POS = 4;          // 16 byte pages: bit 4 = odd
  localparam int RSP_REJECT_POS = 31;       // Response reject flag
  // ****************************************
  // Protection register fields
  // ****************************************
  localparam int WRITE_PROTECT_POS = 1;     // write_protect_bit
  localparam int READ_PROTECT_POS = 0;      // read_protect_bit
  localparam logic [7:0] INIT_PROT_RESET = 8'h00; // Stored value at reset
  // ****************************************
  // Link timing
  // ****************************************
  localparam int LINK_HALF_CYCLES = 4;      // 800 ns link period at 10 MHz
endpackage : cmeu_pkg

/* File: logic/cmeu_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Serial programming link
// ****************************************
interface cmeu_link_if;
  logic link_clk;  // Programmer-made shift clock
  logic load;      // Command latch strobe
  logic shift_in;  // Command bits to device
  logic shift_out; // Response bits and busy handshake
  modport dev (input link_clk, input load, input shift_in,
    output shift_out);
  modport prog (output link_clk, output load, output shift_in,
    input shift_out);
endinterface : cmeu_link_if
`default_nettype wire

/* File: logic/cmeu_programmer.sv */
`timescale 1ns/100ps
`default_nettype none
module cmeu_programmer #(
  parameter int HALF = cmeu_pkg::LINK_HALF_CYCLES // Half link period
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,                 // Pulse: send cmd_i
  input wire logic [31:0] cmd_i,            // Command word
  output logic busy_o,                      // Transfer running
  output logic done_o,                      // Pulse: transfer finished
  output logic [31:0] resp_o,               // Response to previous cmd
  cmeu_link_if.prog link
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    PS_IDLE = 2'h0,
    PS_SHIFT = 2'h1,
    PS_PULSE = 2'h2,
    PS_WAIT = 2'h3
  } cmeu_prog_state_type;
  cmeu_prog_state_type state;
  logic [7:0] div_cnt;                      // Half period divider
  logic tick;                               // Half period elapsed
  logic [4:0] bit_cnt;                      // Bits shifted
  logic pulse_cnt;                          // Launch pulses given
  logic [31:0] cmd_sh;                      // Outgoing word
  logic [31:0] rsp_sh;                      // Incoming word
  logic so_s1, so_s2;                       // Response synchroniser
  logic lead;                               // First low phase doubled
  assign tick = (div_cnt == 8'(HALF - 1));

  // Two flops before the device answer is read
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      {so_s1, so_s2} <= 2'h3;
    else
    begin
      so_s1 <= link.shift_out;
      so_s2 <= so_s1;
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= PS_IDLE;
      div_cnt <= 8'h0;
      bit_cnt <= 5'h0;
      pulse_cnt <= 1'b0;
      lead <= 1'b0;
      cmd_sh <= 32'h0;
      rsp_sh <= 32'h0;
      resp_o <= 32'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      link.link_clk <= 1'b0;
      link.load <= 1'b0;
      link.shift_in <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      div_cnt <= tick ? 8'h0 : div_cnt + 8'h1;
      unique case (state)
        PS_IDLE:
        begin
          div_cnt <= 8'h0;
          if (start_i)
          begin
            // Strobe high with bit 31 already on the wire
            cmd_sh <= cmd_i;
            link.shift_in <= cmd_i[31];
            link.load <= 1'b1;
            bit_cnt <= 5'h0;
            lead <= 1'b1;
            busy_o <= 1'b1;
            state <= PS_SHIFT;
          end
        end
        PS_SHIFT:
        begin
          // Extra half period first, so bit 31 has crossed both
          // synchronisers before the first sample is taken
          if (tick && lead)
            lead <= 1'b0;
          else if (tick && !link.link_clk)
          begin
            // Sample late in the low phase, well after the device moved
            rsp_sh <= {rsp_sh[30:0], so_s2};
            link.link_clk <= 1'b1;
          end
          else if (tick)
          begin
            link.link_clk <= 1'b0;
            if (bit_cnt == 5'h1f)
            begin
              link.load <= 1'b0;
              pulse_cnt <= 1'b0;
              state <= PS_PULSE;
            end
            else
            begin
              bit_cnt <= bit_cnt + 5'h1;
              cmd_sh <= {cmd_sh[30:0], 1'b0};
              link.shift_in <= cmd_sh[30];
            end
          end
        end
        PS_PULSE:
        begin
          // Two full pulses launch execution
          if (tick)
          begin
            link.link_clk <= ~link.link_clk;
            if (link.link_clk)
            begin
              pulse_cnt <= 1'b1;
              if (pulse_cnt)
                state <= PS_WAIT;
            end
          end
        end
        PS_WAIT:
        begin
          // Busy low seen long ago; strobe stays low until ready
          if (so_s2)
          begin
            resp_o <= rsp_sh;
            done_o <= 1'b1;
            busy_o <= 1'b0;
            state <= PS_IDLE;
          end
        end
      endcase
    end
  end
endmodule : cmeu_programmer
`default_nettype wire

/* File: testbench/cmeu_link_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Link protocol checker
// ****************************************
module cmeu_link_checker (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk,
  input wire logic load,
  input wire logic shift_in,
  input wire logic shift_out
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [5:0] hi_cnt;   // Link rises while strobe high
  logic [1:0] lo_cnt;   // Link rises after strobe low
  logic [10:0] low_cnt; // Cycles of response line low
  // Count shift rises inside a frame
  always_ff @(posedge core_clk_i)
    if (!rst_n_i || $rose(load))
      hi_cnt <= 6'h00;
    else if (load && $rose(link_clk))
      hi_cnt <= hi_cnt + 6'h01;
  // Count launch rises after the frame
  always_ff @(posedge core_clk_i)
    if (!rst_n_i || $fell(load))
      lo_cnt <= 2'h0;
    else if (!load && $rose(link_clk))
      lo_cnt <= lo_cnt + 2'h1;
  // Busy length; an erase sweeps the whole array
  always_ff @(posedge core_clk_i)
    if (!rst_n_i || shift_out)
      low_cnt <= 11'h000;
    else
      low_cnt <= low_cnt + 11'h001;
  AST_FULL_WORD: assert property ($fell(load) |-> hi_cnt == 6'h20)
    else $error("frame did not carry 32 shift clocks");
  AST_BIT_SETUP: assert property (link_clk |-> $stable(shift_in))
    else $error("command bit moved while link clock high");
  AST_STROBE_LOW_CLK: assert property ($changed(load) |-> !link_clk)
    else $error("strobe moved while link clock high");
  AST_TWO_PULSES: assert property (!load && $rose(link_clk)
    |-> lo_cnt < 2'h2)
    else $error("more than two launch pulses");
  AST_BUSY_BY_SECOND: assert property (!load && $rose(link_clk)
    && lo_cnt == 2'h1 |-> !shift_out)
    else $error("response line not low by second launch rise");
  AST_WAIT_READY: assert property ($rose(load)
    |-> $past(shift_out) && $past(shift_out, 2))
    else $error("strobe raised while device busy");
  AST_BUSY_BOUNDED: assert property (low_cnt < 11'h578)
    else $error("response line held low too long");
  AST_RESP_ON_RISE: assert property (load && $past(load, 5)
    && $changed(shift_out) |-> $past(link_clk, 2))
    else $error("response bit moved without a shift clock");
  AST_HALF_PERIOD: assert property ($rose(link_clk)
    |-> link_clk [*4] ##1 !link_clk)
    else $error("link clock high phase not four cycles");
endmodule : cmeu_link_checker
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Bench for both link ends
// ****************************************
module tb_top;
  logic core_clk;          // 10 MHz core clock
  logic rst_n;             // Sync reset
  logic prog_mode;         // Programming mode level
  logic start;             // Programmer start pulse
  logic [31:0] cmd;        // Command word to send
  logic [9:0] rd_addr;     // Core fetch address
  logic busy;              // Programmer busy
  logic done;              // Transfer done pulse
  logic [31:0] resp;       // Response to previous command
  logic [7:0] rd_data;     // Core fetch data
  logic [7:0] shadow;      // Volatile protect copy
  logic [7:0] stored;      // Stored protect copy
  logic even_done;         // Even half erased
  logic odd_done;          // Odd half erased
  logic [31:0] r;          // Captured response
  logic [7:0] e_dat, o_dat, d_dat, w_dat, pd; // Random payloads
  logic [9:0] a;           // Random code address
  int failures;
  int checks_done;
  cmeu_link_if link_if_i ();
  // Protected part at power-up, so unlock is exercised
  cmeu_device #(.NV_RESET(8'h03)) cmeu_device_i (.core_clk_i(core_clk),
    .rst_n_i(rst_n), .prog_mode_i(prog_mode), .code_rd_addr_i(rd_addr),
    .code_rd_data_o(rd_data), .protect_shadow_o(shadow),
    .protect_stored_o(stored), .erase_even_done_o(even_done),
    .erase_odd_done_o(odd_done), .link(link_if_i.dev));
  cmeu_programmer cmeu_programmer_i (.core_clk_i(core_clk),
    .rst_n_i(rst_n), .start_i(start), .cmd_i(cmd), .busy_o(busy),
    .done_o(done), .resp_o(resp), .link(link_if_i.prog));
  cmeu_link_checker cmeu_link_checker_i (.core_clk_i(core_clk),
    .rst_n_i(rst_n), .link_clk(link_if_i.link_clk), .load(link_if_i.load),
    .shift_in(link_if_i.shift_in), .shift_out(link_if_i.shift_out));
  // ****************************************
  // Clock
  // ****************************************
  always #50 core_clk = ~core_clk;
  // ****************************************
  // Helpers
  // ****************************************
  // Command word: write, init, code, erase, address, data
  function automatic logic [31:0] mk(input logic w, input logic ini,
    input logic code, input logic ers, input logic [9:0] ad,
    input logic [7:0] d);
    mk = {w, ini, 1'b0, code, 5'h00, ers, 4'h0, ad, d};
  endfunction : mk
  // Expected response: reject flag and read byte
  function automatic logic [31:0] rsp(input logic rej, input logic [7:0] d);
    rsp = {rej, 23'h000000, d};
  endfunction : rsp
  task automatic summarize();
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One full transfer; hands back the previous command's response
  task automatic send(input logic [31:0] c, output logic [31:0] rr);
    int n;
    n = 0;
    cmd = c;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    chk({31'h0, busy}, 32'h1);
    // Bounded wait; erase busy is the long case
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 3000)
    begin
      failures++;
      summarize();
    end
    rr = resp;
    chk({31'h0, busy}, 32'h0);
    @(negedge core_clk);
  endtask : send
  // Core-side fetch, one cycle latency
  task automatic fetch(input logic [9:0] ad, input logic [7:0] d);
    rd_addr = ad;
    @(negedge core_clk);
    chk({24'h000000, rd_data}, {24'h000000, d});
  endtask : fetch
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    prog_mode = 1'b1;
    start = 1'b0;
    cmd = 32'h0;
    rd_addr = 10'h000;
    failures = 0;
    checks_done = 0;
    void'($urandom(32'h86365471));
    e_dat = 8'($urandom);
    o_dat = 8'($urandom);
    d_dat = 8'($urandom);
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    chk({24'h0, shadow}, 32'h03);
    chk({24'h0, stored}, 32'h03);
    // Protected: plain write, then bad erase address
    send(mk(1'b1, 1'b0, 1'b1, 1'b0, 10'h005, d_dat), r);
    send(mk(1'b1, 1'b0, 1'b1, 1'b1, 10'h011, e_dat), r);
    chk(r, rsp(1'b1, 8'h00));
    send(mk(1'b0, 1'b0, 1'b1, 1'b0, 10'h005, 8'h00), r);
    chk(r, rsp(1'b1, 8'h00));
    chk({30'h0, even_done, odd_done}, 32'h0);
    // Even half only: shadow must stay protected
    send(mk(1'b1, 1'b0, 1'b1, 1'b1, cmeu_pkg::ADDR_EVEN, e_dat), r);
    chk(r, rsp(1'b1, 8'h00));
    chk({30'h0, even_done, odd_done}, 32'h2);
    chk({24'h0, shadow}, 32'h03);
    fetch(10'h020, e_dat);
    fetch(10'h3c7, e_dat);
    // Odd half: unlock despite write protect set
    send(mk(1'b1, 1'b0, 1'b1, 1'b1, cmeu_pkg::ADDR_ODD, o_dat), r);
    send(mk(1'b0, 1'b0, 1'b1, 1'b0, 10'h005, 8'h00), r);
    chk({31'h0, r[31]}, 32'h0);
    chk({30'h0, even_done, odd_done}, 32'h3);
    chk({24'h0, shadow}, 32'h00);
    chk({24'h0, stored}, 32'h03);
    fetch(10'h010, o_dat);
    fetch(10'h3f5, o_dat);
    fetch(10'h005, e_dat);
    // Random reload of code memory after unlock
    for (int i = 0; i < 4; i++)
    begin
      a = 10'($urandom);
      w_dat = 8'($urandom);
      send(mk(1'b1, 1'b0, 1'b1, 1'b0, a, w_dat), r);
      if (i > 0)
        chk(r, rsp(1'b0, pd));
      send(mk(1'b0, 1'b0, 1'b1, 1'b0, a, 8'h00), r);
      chk(r, rsp(1'b0, 8'h00));
      pd = w_dat;
    end
    // Data memory must survive a further erase
    send(mk(1'b1, 1'b0, 1'b0, 1'b0, 10'h003, d_dat), r);
    chk(r, rsp(1'b0, pd));
    send(mk(1'b1, 1'b0, 1'b1, 1'b1, cmeu_pkg::ADDR_EVEN, e_dat), r);
    send(mk(1'b0, 1'b0, 1'b0, 1'b0, 10'h003, 8'h00), r);
    send(mk(1'b1, 1'b1, 1'b0, 1'b0, cmeu_pkg::INIT_PROT_OFFSET, 8'h00), r);
    chk(r, rsp(1'b0, d_dat));
    // Stored copy rewritten: permanent unlock
    send(mk(1'b0, 1'b1, 1'b0, 1'b0, cmeu_pkg::INIT_PROT_OFFSET, 8'h00), r);
    chk({24'h0, stored}, 32'h00);
    // Leave programming mode: flags drop
    prog_mode = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({30'h0, even_done, odd_done}, 32'h0);
    chk({24'h0, shadow}, 32'h00);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
